/* File: rtl/sram_ecc_access_and_debug.sv */
// ecc wrapper for on-chip sram with system port and register debug port
`timescale 1ns/100ps
`default_nettype none
module sram_ecc_access_and_debug #(
  parameter int MEM_AW = 11
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // device mode pin and initialiser status
  input wire logic SPECIAL_MODE_I,
  input wire logic MEM_INIT_DONE_I,
  // avalon-mm register slave
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // system memory port
  input wire logic [MEM_AW+1:0] SYS_ADDR_I,
  input wire logic SYS_READ_I,
  input wire logic SYS_WRITE_I,
  input wire logic [3:0] SYS_BE_I,
  input wire logic [31:0] SYS_WDATA_I,
  output logic [31:0] SYS_RDATA_O,
  output logic SYS_ACK_O,
  output logic SYS_ERR_O,
  // error reporting
  output logic DOUBLE_ERR_O,
  output logic SINGLE_ERR_IRQ_O
);
  localparam sram_ecc_pkg::ptr_t PTR_MASK =
    sram_ecc_pkg::ptr_t'((64'h1 << (MEM_AW + 2)) - 64'h2);

  generate
    if (MEM_AW < 1 || MEM_AW > 22) begin : g_bad_aw
      $error("MEM_AW must lie between 1 and 22");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_RMW, S_STALL} phase_t;

  typedef struct packed {
    phase_t st;
    logic ack;
    logic err;
    logic dbe;
    logic [31:0] rdata;
    logic [43:0] rmw_word;
    logic rmw_sbe;
    logic rmw_dbe;
    logic [MEM_AW-1:0] rmw_idx;
    logic [23:0] debug_address_pointer;
    logic [15:0] debug_raw_word;
    logic [5:0] debug_check_bits;
    logic read_repair_disable;
    logic debug_write_cmd;
    logic debug_read_cmd;
    logic single_error_flag;
    logic single_error_irq_enable;
    logic irq;
    logic spec_m;
    logic spec;
    logic av_wait;
    logic [31:0] av_rdata;
  } state_t;

  state_t q;
  state_t d;

  mem_port_if #(.MEM_AW(MEM_AW)) mem ();

  ecc_store #(.MEM_AW(MEM_AW)) u_store (
    .clk_i(REF_CLK_I),
    .port(mem)
  );

  // ---------------------------------------------------------------
  // read-side check on both half words
  // ---------------------------------------------------------------
  logic [1:0][15:0] fix_half;
  logic [1:0] sgl_half;
  logic [1:0] dbl_half;

  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_half
      ecc_codec u_codec (
        .data_i(mem.rdata[h*22 +: 16]),
        .check_i(mem.rdata[h*22+16 +: 6]),
        .fixed_o(fix_half[h]),
        .single_o(sgl_half[h]),
        .double_o(dbl_half[h])
      );
    end
  endgenerate

  logic [31:0] fixed32;
  logic any_dbl;
  logic any_sgl;
  logic [31:0] merged32;
  logic [MEM_AW-1:0] sys_idx;
  logic [MEM_AW-1:0] dbg_idx;
  logic sys_req;
  logic aligned;
  logic can_take;
  logic pend;
  logic sbe_set;
  logic flag_clr;
  logic av_take;
  logic av_commit;
  logic [31:0] rd_val;
  logic [31:0] wv;

  assign fixed32 = {fix_half[1], fix_half[0]};
  assign any_dbl = |dbl_half;
  assign any_sgl = (|sgl_half) & ~any_dbl;
  assign merged32 = sram_ecc_pkg::byte_merge(fixed32, SYS_WDATA_I,
                                             SYS_BE_I);
  assign sys_idx = SYS_ADDR_I[MEM_AW+1:2];
  assign dbg_idx = q.debug_address_pointer[MEM_AW+1:2];
  assign sys_req = SYS_READ_I | SYS_WRITE_I;
  assign aligned = (SYS_BE_I == sram_ecc_pkg::BE_LO) |
                   (SYS_BE_I == sram_ecc_pkg::BE_HI) |
                   (SYS_BE_I == sram_ecc_pkg::BE_ALL);
  // ack cycle blocks a new take because the master still holds its request
  assign can_take = (q.st == S_IDLE) & ~q.ack & MEM_INIT_DONE_I;
  assign pend = q.debug_write_cmd | q.debug_read_cmd;
  assign av_take = (AVS_READ_I | AVS_WRITE_I) & q.av_wait;
  assign av_commit = AVS_WRITE_I & ~q.av_wait;

  // ---------------------------------------------------------------
  // register read view
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 32'h00000000;
    case (AVS_ADDRESS_I)
      sram_ecc_pkg::REG_STATUS: rd_val[0] = MEM_INIT_DONE_I;
      sram_ecc_pkg::REG_IRQ_EN: rd_val[0] = q.single_error_irq_enable;
      sram_ecc_pkg::REG_FLAG: rd_val[0] = q.single_error_flag;
      sram_ecc_pkg::REG_PTR: rd_val[23:0] = q.debug_address_pointer;
      sram_ecc_pkg::REG_RAW_WORD: rd_val[15:0] = q.debug_raw_word;
      sram_ecc_pkg::REG_CHECK_BITS: rd_val[5:0] = q.debug_check_bits;
      sram_ecc_pkg::REG_CMD: begin
        rd_val[sram_ecc_pkg::CMD_REPAIR_DIS_BIT] = q.read_repair_disable;
        rd_val[sram_ecc_pkg::CMD_WRITE_BIT] = q.debug_write_cmd;
        rd_val[sram_ecc_pkg::CMD_READ_BIT] = q.debug_read_cmd;
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  assign wv = sram_ecc_pkg::byte_merge(rd_val, AVS_WRITEDATA_I,
                                       AVS_BYTEENABLE_I);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.err = 1'b0;
    d.dbe = 1'b0;
    sbe_set = 1'b0;
    flag_clr = 1'b0;
    mem.idx = sys_idx;
    mem.we = 2'b00;
    mem.wdata = sram_ecc_pkg::pack_word(SYS_WDATA_I);
    d.spec_m = SPECIAL_MODE_I;
    d.spec = q.spec_m;

    case (q.st)
      S_IDLE: begin
        if (can_take && sys_req) begin
          if (SYS_WRITE_I) begin
            if (aligned) begin
              mem.we = {SYS_BE_I[2], SYS_BE_I[0]};
              d.ack = 1'b1;
            end else begin
              d.st = S_RMW;
              d.rmw_word = sram_ecc_pkg::pack_word(merged32);
              d.rmw_sbe = any_sgl;
              d.rmw_dbe = any_dbl;
              d.rmw_idx = sys_idx;
            end
          end else begin
            d.ack = 1'b1;
            d.rdata = fixed32;
            d.err = any_dbl;
            d.dbe = any_dbl;
            if (any_sgl) begin
              sbe_set = 1'b1;
              if (!q.read_repair_disable) begin
                mem.we = 2'b11;
                mem.wdata = sram_ecc_pkg::pack_word(fixed32);
                d.st = S_STALL;
              end
            end
          end
        end else if (can_take && pend) begin
          // lowest priority: only when no system request waits
          mem.idx = dbg_idx;
          if (q.debug_write_cmd) begin
            mem.we = q.debug_address_pointer[1] ? 2'b10 : 2'b01;
            mem.wdata = {q.debug_check_bits, q.debug_raw_word,
                         q.debug_check_bits, q.debug_raw_word};
            d.debug_write_cmd = 1'b0;
          end else begin
            if (q.debug_address_pointer[1]) begin
              d.debug_raw_word = mem.rdata[37:22];
              d.debug_check_bits = mem.rdata[43:38];
            end else begin
              d.debug_raw_word = mem.rdata[15:0];
              d.debug_check_bits = mem.rdata[21:16];
            end
            d.debug_read_cmd = 1'b0;
          end
        end
      end
      S_RMW: begin
        mem.idx = q.rmw_idx;
        mem.wdata = q.rmw_word;
        if (!q.rmw_dbe) begin
          mem.we = 2'b11;
        end
        sbe_set = q.rmw_sbe;
        d.ack = 1'b1;
        d.err = q.rmw_dbe;
        d.dbe = q.rmw_dbe;
        d.st = S_IDLE;
      end
      S_STALL: begin
        // hold one cycle past the ack so the next read waits an extra cycle
        if (!q.ack) begin
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase

    // register bus: take, then acknowledge with waitrequest low
    if (av_take) begin
      d.av_wait = 1'b0;
      d.av_rdata = rd_val;
    end
    if (!q.av_wait) begin
      d.av_wait = 1'b1;
    end
    if (av_commit) begin
      case (AVS_ADDRESS_I)
        sram_ecc_pkg::REG_IRQ_EN: d.single_error_irq_enable = wv[0];
        sram_ecc_pkg::REG_FLAG: begin
          flag_clr = AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[0];
        end
        sram_ecc_pkg::REG_PTR: begin
          d.debug_address_pointer = wv[23:0] & PTR_MASK;
        end
        sram_ecc_pkg::REG_RAW_WORD: begin
          if (!pend) begin
            d.debug_raw_word = wv[15:0];
          end
        end
        sram_ecc_pkg::REG_CHECK_BITS: begin
          if (!pend) begin
            d.debug_check_bits = wv[5:0];
          end
        end
        sram_ecc_pkg::REG_CMD: begin
          if (q.spec) begin
            d.read_repair_disable = wv[sram_ecc_pkg::CMD_REPAIR_DIS_BIT];
            if (!pend) begin
              if (wv[sram_ecc_pkg::CMD_WRITE_BIT]) begin
                d.debug_write_cmd = 1'b1;
              end else if (wv[sram_ecc_pkg::CMD_READ_BIT]) begin
                d.debug_read_cmd = 1'b1;
              end
            end
          end
        end
        default: d.av_wait = 1'b1;
      endcase
    end

    // a new error in the clearing cycle keeps the flag set
    d.single_error_flag = (q.single_error_flag & ~flag_clr) | sbe_set;
    d.irq = q.single_error_flag & q.single_error_irq_enable;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      q <= '0;
      q.av_wait <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign AVS_READDATA_O = q.av_rdata;
  assign AVS_WAITREQUEST_O = q.av_wait;
  assign SYS_RDATA_O = q.rdata;
  assign SYS_ACK_O = q.ack;
  assign SYS_ERR_O = q.err;
  assign DOUBLE_ERR_O = q.dbe;
  assign SINGLE_ERR_IRQ_O = q.irq;
endmodule : sram_ecc_access_and_debug
`default_nettype wire

/* File: rtl/sram_ecc_pkg.sv */
// shared constants, register map and check-bit helpers for the sram ecc block
`default_nettype none
package sram_ecc_pkg;

  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int CHK_W = 6;
  localparam int HALF_W = 22;
  localparam int WORD_W = 44;
  localparam int PTR_W = 24;
  localparam int REG_IDX_W = 4;

  typedef logic [23:0] ptr_t;

  // check bit k is the inverted parity of the data masked by entry k
  localparam logic [5:0][15:0] ECC_MASK = {
    16'h993C, 16'h3E8A, 16'hEE60, 16'hE1D1, 16'h13C7, 16'h443F
  };

  // ---------------------------------------------------------------
  // register word indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_EN = 4'h1;
  localparam logic [3:0] REG_FLAG = 4'h2;
  localparam logic [3:0] REG_PTR = 4'h7;
  localparam logic [3:0] REG_RAW_WORD = 4'hC;
  localparam logic [3:0] REG_CHECK_BITS = 4'hE;
  localparam logic [3:0] REG_CMD = 4'hF;

  // command register fields
  localparam int CMD_READ_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_REPAIR_DIS_BIT = 7;

  // reset values
  localparam logic [7:0] RST_CMD = 8'h00;
  localparam logic [5:0] RST_CHECK_BITS = 6'h00;
  localparam logic [15:0] RST_RAW_WORD = 16'h0000;
  localparam logic [23:0] RST_PTR = 24'h000000;

  // byte enables of the writes that need no read phase
  localparam logic [3:0] BE_LO = 4'h3;
  localparam logic [3:0] BE_HI = 4'hC;
  localparam logic [3:0] BE_ALL = 4'hF;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] ecc_gen(input logic [15:0] data);
    logic [5:0] c;
    c = 6'h00;
    for (int k = 0; k < CHK_W; k++) begin
      c[k] = ~(^(data & ECC_MASK[k]));
    end
    return c;
  endfunction : ecc_gen

  // two halves, each with freshly generated check bits
  function automatic logic [43:0] pack_word(input logic [31:0] w);
    return {ecc_gen(w[31:16]), w[31:16], ecc_gen(w[15:0]), w[15:0]};
  endfunction : pack_word

  function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return m;
  endfunction : byte_merge

endpackage : sram_ecc_pkg
`default_nettype wire

/* File: rtl/mem_port_if.sv */
// port between the access controller and the storage array
`timescale 1ns/100ps
`default_nettype none
interface mem_port_if #(
  parameter int MEM_AW = 11
);
  logic [MEM_AW-1:0] idx;
  logic [1:0] we;
  logic [43:0] wdata;
  logic [43:0] rdata;

  modport ctrl (output idx, output we, output wdata, input rdata);
  modport array (input idx, input we, input wdata, output rdata);
endinterface : mem_port_if
`default_nettype wire

/* File: rtl/ecc_codec.sv */
// syndrome check and single-bit correction for one 16-bit half word
`timescale 1ns/100ps
`default_nettype none
module ecc_codec (
  // stored half word
  input wire logic [15:0] data_i,
  input wire logic [5:0] check_i,
  // result
  output logic [15:0] fixed_o,
  output logic single_o,
  output logic double_o
);
  logic [5:0] syn;
  logic [15:0] flip;
  logic [15:0][5:0] col;

  // inversion cancels in the syndrome, so zero means clean
  assign syn = check_i ^ sram_ecc_pkg::ecc_gen(data_i);

  genvar i;
  genvar k;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      for (k = 0; k < 6; k++) begin : g_col
        assign col[i][k] = sram_ecc_pkg::ECC_MASK[k][i];
      end
      assign flip[i] = (syn == col[i]);
    end
  endgenerate

  assign fixed_o = data_i ^ flip;
  // a lone check-bit error leaves the data intact but still counts
  assign single_o = (|flip) | $onehot(syn);
  assign double_o = (syn != 6'h00) & ~single_o;
endmodule : ecc_codec
`default_nettype wire

/* File: rtl/ecc_store.sv */
// flip-flop storage array, two half words with check bits per entry
`timescale 1ns/100ps
`default_nettype none
module ecc_store #(
  parameter int MEM_AW = 11
) (
  // clock
  input wire logic clk_i,
  // access port
  mem_port_if.array port
);
  localparam int DEPTH = 2 ** MEM_AW;

  typedef struct packed {
    logic [DEPTH-1:0][43:0] words;
  } store_t;

  store_t q;
  store_t d;

  // no reset: contents are set up by the power-up initialiser outside
  always_comb begin
    d = q;
    if (port.we[0]) begin
      d.words[port.idx][21:0] = port.wdata[21:0];
    end
    if (port.we[1]) begin
      d.words[port.idx][43:22] = port.wdata[43:22];
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  assign port.rdata = q.words[port.idx];
endmodule : ecc_store
`default_nettype wire

/* File: verification/sram_ecc_monitor.sv */
// assertion checker watching the ports of the sram ecc block
`timescale 1ns/100ps
`default_nettype none
module sram_ecc_monitor #(
  parameter int MEM_AW = 11
) (
  // clock, reset and initialiser status
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic MEM_INIT_DONE_I,
  // register bus handshake
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  // system port
  input wire logic SYS_READ_I,
  input wire logic SYS_WRITE_I,
  input wire logic [3:0] SYS_BE_I,
  input wire logic [31:0] SYS_RDATA_O,
  input wire logic SYS_ACK_O,
  input wire logic SYS_ERR_O,
  input wire logic DOUBLE_ERR_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  logic av_req;
  logic aligned;
  assign av_req = AVS_READ_I | AVS_WRITE_I;
  assign aligned = SYS_BE_I inside {4'h3, 4'hC, 4'hF};
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_AV_ANSWER: assert property (av_req && AVS_WAITREQUEST_O |=>
    !AVS_WAITREQUEST_O) else $error("register request not answered");
  AST_AV_ONE: assert property (!AVS_WAITREQUEST_O |=>
    AVS_WAITREQUEST_O) else $error("waitrequest low too long");
  AST_RD_LAT: assert property ($rose(SYS_READ_I) && MEM_INIT_DONE_I
    |-> ##[1:2] SYS_ACK_O) else $error("read not acked in time");
  AST_WR_ONE: assert property ($rose(SYS_WRITE_I) && aligned &&
    MEM_INIT_DONE_I |=> SYS_ACK_O) else $error("aligned write slow");
  AST_WR_TWO: assert property ($rose(SYS_WRITE_I) && !aligned &&
    MEM_INIT_DONE_I |=> !SYS_ACK_O ##1 SYS_ACK_O)
    else $error("partial write not two cycles");
  AST_ACK_PULSE: assert property (SYS_ACK_O |=> !SYS_ACK_O)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (SYS_ACK_O |->
    SYS_READ_I || SYS_WRITE_I) else $error("ack without request");
  AST_ERR_ACK: assert property (SYS_ERR_O |-> SYS_ACK_O)
    else $error("error without ack");
  AST_ERR_OUT: assert property (SYS_ERR_O == DOUBLE_ERR_O)
    else $error("double error output disagrees");
  AST_RD_HOLD: assert property (!(SYS_ACK_O && SYS_READ_I) |->
    $stable(SYS_RDATA_O)) else $error("read data moved without ack");
endmodule : sram_ecc_monitor

bind sram_ecc_access_and_debug sram_ecc_monitor #(.MEM_AW(MEM_AW)) mon (
  .REF_CLK_I(REF_CLK_I),
  .RST_I(RST_I),
  .MEM_INIT_DONE_I(MEM_INIT_DONE_I),
  .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .SYS_READ_I(SYS_READ_I),
  .SYS_WRITE_I(SYS_WRITE_I),
  .SYS_BE_I(SYS_BE_I),
  .SYS_RDATA_O(SYS_RDATA_O),
  .SYS_ACK_O(SYS_ACK_O),
  .SYS_ERR_O(SYS_ERR_O),
  .DOUBLE_ERR_O(DOUBLE_ERR_O)
);
`default_nettype wire

/* File: verification/sys_initiator.sv */
// system bus initiator model driving the memory port
`timescale 1ns/100ps
`default_nettype none
module sys_initiator #(
  parameter int AW = 6
) (
  // clock
  input wire logic clk_i,
  // request
  output logic [AW-1:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o,
  // answer
  input wire logic [31:0] rdata_i,
  input wire logic ack_i,
  input wire logic err_i
);
  initial begin
    addr_o = '0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    be_o = 4'h0;
    wdata_o = 32'h0;
  end
  // caller sits just after a rising edge; request holds until ack sampled
  task automatic xfer(input logic w, input logic [AW-1:0] a,
                      input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output int n);
    n = 0;
    rd_o <= !w;
    wr_o <= w;
    addr_o <= a;
    be_o <= be;
    wdata_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    q = rdata_i;
    e = err_i;
  endtask : xfer
  // released lines flip so a stale value can never pass for a live one
  task automatic idle();
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= ~addr_o;
    be_o <= ~be_o;
    wdata_o <= ~wdata_o;
    @(posedge clk_i);
  endtask : idle
endmodule : sys_initiator
`default_nettype wire

/* File: verification/sram_ecc_access_and_debug_tb.sv */
// self-checking bench for the sram ecc block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sram_ecc_access_and_debug_tb;
  localparam int AW = 4;
  logic clk, rst, special, init_done, avs_rd, avs_wr, avs_wait;
  logic ack, err, dbl, irq, sys_rd, sys_wr, se;
  logic [3:0] avs_addr, avs_be, sys_be, w, be;
  logic [31:0] avs_wd, avs_rdata, sys_wd, sys_rdata, rv, sq, d, r;
  logic [AW+1:0] sys_addr;
  logic [31:0] sh [16];
  logic [15:0] lo;
  int sn, seed, bad_count = 0, checks_done = 0, cycles = 0, dbl_n = 0;

  sram_ecc_access_and_debug #(.MEM_AW(AW)) dut (
    .REF_CLK_I(clk), .RST_I(rst), .SPECIAL_MODE_I(special),
    .MEM_INIT_DONE_I(init_done), .AVS_ADDRESS_I(avs_addr),
    .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr), .AVS_WRITEDATA_I(avs_wd),
    .AVS_BYTEENABLE_I(avs_be), .AVS_READDATA_O(avs_rdata),
    .AVS_WAITREQUEST_O(avs_wait), .SYS_ADDR_I(sys_addr),
    .SYS_READ_I(sys_rd), .SYS_WRITE_I(sys_wr), .SYS_BE_I(sys_be),
    .SYS_WDATA_I(sys_wd), .SYS_RDATA_O(sys_rdata), .SYS_ACK_O(ack),
    .SYS_ERR_O(err), .DOUBLE_ERR_O(dbl), .SINGLE_ERR_IRQ_O(irq));
  sys_initiator #(.AW(AW + 2)) ini (
    .clk_i(clk), .addr_o(sys_addr), .rd_o(sys_rd), .wr_o(sys_wr),
    .be_o(sys_be), .wdata_o(sys_wd), .rdata_i(sys_rdata), .ack_i(ack),
    .err_i(err));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // count double error pulses so the outward report is checked on its own
  always @(posedge clk) begin
    if (dbl === 1'b1) begin
      dbl_n <= dbl_n + 1;
    end
  end
  // ---------------------------------------------------------------
  // expectations and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [5:0] chk6(input logic [15:0] v);
    logic [15:0] m [6] = '{16'h443F, 16'h13C7, 16'hE1D1, 16'hEE60,
                           16'h3E8A, 16'h993C};
    for (int k = 0; k < 6; k++) begin
      chk6[k] = ~(^(v & m[k]));
    end
  endfunction : chk6
  function automatic logic [31:0] mrg(input logic [31:0] o, n,
                                      input logic [3:0] m);
    for (int b = 0; b < 4; b++) begin
      if (m[b]) begin
        o[8*b +: 8] = n[8*b +: 8];
      end
    end
    return o;
  endfunction : mrg
  task automatic av(input logic wn, input logic [3:0] a, input logic [31:0] v);
    avs_rd <= !wn;
    avs_wr <= wn;
    avs_addr <= a;
    avs_wd <= v;
    do @(posedge clk); while (avs_wait !== 1'b0);
    rv = avs_rdata;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
    @(posedge clk);
  endtask : av
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    av(1'b1, a, v);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    av(1'b0, a, 32'h0);
  endtask : rd
  // a debug access ends once software sees both command bits low, or after 20 reads of the command register
  task automatic dcmd(input logic [7:0] c);
    wr(4'hF, {24'h0, c});
    rv = 32'h3;
    for (int i = 0; i < 20 && rv[1:0] != 2'b00; i++) begin
      rd(4'hF);
    end
  endtask : dcmd
  task automatic sx(input logic wn, input logic [3:0] a,
                    input logic [3:0] m, input logic [31:0] v);
    ini.xfer(wn, {a, 2'b00}, m, v, sq, se, sn);
    ini.idle();
  endtask : sx
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    seed = 97;
    rst = 1'b1;
    special = 1'b0;
    init_done = 1'b0;
    avs_rd = 1'b0;
    avs_wr = 1'b0;
    avs_addr = 4'h0;
    avs_be = 4'hF;
    avs_wd = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      rd(4'(i));
      `CHK(rv, 32'h0)
    end
    wr(4'h3, 32'hFFFFFFFF);
    wr(4'hF, 32'h80);
    rd(4'hF);
    `CHK(rv, 32'h0)
    special <= 1'b1;
    repeat (4) @(posedge clk);
    wr(4'h7, 32'hFFFFFFFF);
    rd(4'h7);
    `CHK(rv, (32'h1 << (AW + 2)) - 32'h2)
    wr(4'hE, 32'hFF);
    rd(4'hE);
    `CHK(rv, 32'h3F)
    // memory still initialising: the debug write must stay pending
    wr(4'h7, 32'h0);
    wr(4'hC, 32'hA5C3);
    wr(4'hE, 32'(chk6(16'hA5C3)));
    wr(4'hF, 32'h3);
    rd(4'hF);
    `CHK(rv, 32'h2)
    wr(4'hF, 32'h1);
    wr(4'hF, 32'h0);
    wr(4'hC, 32'h1111);
    rd(4'hF);
    `CHK(rv, 32'h2)
    rd(4'hC);
    `CHK(rv, 32'hA5C3)
    init_done <= 1'b1;
    dcmd(8'h00);
    `CHK(rv, 32'h0)
    rd(4'h0);
    `CHK(rv, 32'h1)
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      sx(1'b1, 4'(i), (i == 0) ? 4'hC : 4'hF, d);
      sh[i] = (i == 0) ? {d[31:16], 16'hA5C3} : d;
      `CHK(sn, 2)
    end
    for (int i = 0; i < 16; i++) begin
      sx(1'b0, 4'(i), 4'hF, 32'h0);
      `CHK(sq, sh[i])
    end
    repeat (40) begin
      r = $random(seed);
      d = $random(seed);
      w = r[3:0];
      be = r[7:4];
      sx(1'b1, w, be, d);
      sh[w] = mrg(sh[w], d, be);
      `CHK(sn, (be inside {4'h3, 4'hC, 4'hF}) ? 2 : 3)
      sx(1'b0, w, 4'hF, 32'h0);
      `CHK(sq, sh[w])
    end
    // single error on a read, repaired, then a back-to-back read
    lo = sh[5][15:0];
    wr(4'h7, 32'h14);
    wr(4'hC, {16'h0, lo ^ 16'h0004});
    wr(4'hE, 32'(chk6(lo)));
    dcmd(8'h02);
    ini.xfer(1'b0, 6'h14, 4'hF, 32'h0, sq, se, sn);
    `CHK(sq, sh[5])
    ini.xfer(1'b0, 6'h14, 4'hF, 32'h0, sq, se, sn);
    `CHK(sn, 3)
    ini.idle();
    rd(4'h2);
    `CHK(rv, 32'h1)
    `CHK(irq, 1'b0)
    wr(4'h1, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(4'h2, 32'h0);
    rd(4'h2);
    `CHK(rv, 32'h1)
    // the clearing one sits in a disabled byte lane, so nothing clears
    avs_be <= 4'hE;
    wr(4'h2, 32'h1);
    avs_be <= 4'hF;
    rd(4'h2);
    `CHK(rv, 32'h1)
    wr(4'h2, 32'h1);
    rd(4'h2);
    `CHK(rv, 32'h0)
    dcmd(8'h01);
    rd(4'hC);
    `CHK(rv, {16'h0, lo})
    rd(4'hE);
    `CHK(rv, 32'(chk6(lo)))
    rd(4'h2);
    `CHK(rv, 32'h0)
    // repair disabled: data corrected, memory left as it was
    wr(4'hC, {16'h0, lo ^ 16'h0004});
    dcmd(8'h82);
    sx(1'b0, 4'h5, 4'hF, 32'h0);
    `CHK(sq, sh[5])
    dcmd(8'h81);
    rd(4'hC);
    `CHK(rv, {16'h0, lo ^ 16'h0004})
    rd(4'hF);
    `CHK(rv, 32'h80)
    wr(4'h2, 32'h1);
    // double error on read and on a partial write
    wr(4'hC, {16'h0, lo ^ 16'h0003});
    dcmd(8'h02);
    sx(1'b0, 4'h5, 4'hF, 32'h0);
    `CHK(se, 1'b1)
    sx(1'b1, 4'h5, 4'h1, 32'hFF);
    `CHK(se, 1'b1)
    `CHK(dbl_n, 2)
    dcmd(8'h01);
    rd(4'hC);
    `CHK(rv, {16'h0, lo ^ 16'h0003})
    rd(4'h2);
    `CHK(rv, 32'h0)
    `CHK(dbl_n, 2)
    // single error met by the read phase of a partial write
    lo = sh[6][31:16];
    wr(4'h7, 32'h1A);
    wr(4'hC, {16'h0, lo ^ 16'h0100});
    wr(4'hE, 32'(chk6(lo)));
    dcmd(8'h02);
    sx(1'b1, 4'h6, 4'h1, 32'h5A);
    sh[6] = mrg(sh[6], 32'h5A, 4'h1);
    `CHK(se, 1'b0)
    rd(4'h2);
    `CHK(rv, 32'h1)
    dcmd(8'h01);
    rd(4'hC);
    `CHK(rv, {16'h0, lo})
    sx(1'b0, 4'h6, 4'hF, 32'h0);
    `CHK(sq, sh[6])
    tally_and_finish();
  end
endmodule : sram_ecc_access_and_debug_tb
`default_nettype wire
